/* common/cgis_pkg.sv */
// package for the gate input selection stage: register map, field layout,
// reset values. assumes a 32-bit apb slave, one aligned word per register.
//
// Notes on behaviour
// - set true enable passes source into gate
// - set negated enable passes inverted source
// - cleared enable excludes that polarity from gate
// - low register bits 15..8 steer gate two
// - low register bits 7..0 steer gate one
// - high register bits 15..8 steer gate four
// - high register bits 7..0 steer gate three
// - gate enables read/write, reset to zero
// - fourth cell source-4 codes 001..111 mapped
// - each mux gives true/negated; gate ORs enabled
// - gate polarity bit inverts gate output
// - each mux picks one of eight via 3-bit field
package cgis_pkg;
   localparam logic [11:0] CGIS_OFF_GATE_LOW  = 12'h000;
   localparam logic [11:0] CGIS_OFF_GATE_HIGH = 12'h004;
   localparam logic [11:0] CGIS_OFF_SELECT    = 12'h008;
   localparam logic [11:0] CGIS_OFF_POLARITY  = 12'h00c;
   localparam logic [11:0] CGIS_OFF_STATUS    = 12'h010;
   localparam int CGIS_ADDR_W    = 12;
   localparam int CGIS_REG_W     = 16;
   localparam int CGIS_NUM_SRC   = 4;
   localparam int CGIS_NUM_GATE  = 4;
   localparam int CGIS_SEL_W     = 3;
   localparam int CGIS_SEL_STEP  = 4;
   localparam int CGIS_GATE_BITS = 8;
   localparam logic [15:0] CGIS_GATE_RST   = 16'h0000;
   localparam logic [15:0] CGIS_SEL_RST    = 16'h0000;
   localparam logic [15:0] CGIS_SEL_MASK   = 16'h7777;
   localparam logic [3:0]  CGIS_POL_RST    = 4'h0;
   // source-4 codes of the fourth cell
   localparam logic [2:0] CGIS_S4_THIRD_CELL = 3'h1;
   localparam logic [2:0] CGIS_S4_CMP_THREE  = 3'h2;
   localparam logic [2:0] CGIS_S4_PWM8_LOW   = 3'h3;
   localparam logic [2:0] CGIS_S4_TRIG_GEN   = 3'h4;
   localparam logic [2:0] CGIS_S4_PWM2_HIGH  = 3'h5;
   localparam logic [2:0] CGIS_S4_PWM_CLOCK  = 3'h6;
   localparam logic [2:0] CGIS_S4_OC_THREE   = 3'h7;
endpackage

/* common/cgis_cfg_if.sv */
// configuration carried from the register file to the gate stage.
// assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cgis_cfg_if;
   logic [15:0] gate_low;
   logic [15:0] gate_high;
   logic [15:0] sel;
   logic [3:0]  pol;
   logic [3:0]  gate_out;
   modport regs (output gate_low, gate_high, sel, pol, input gate_out);
   modport gates (input gate_low, gate_high, sel, pol, output gate_out);
endinterface
`default_nettype wire

/* rtl/cgis_gate_stage.sv */
// four source muxes and four or-gates with polarity, registered.
// assumes source inputs synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module cgis_gate_stage
   import cgis_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   input  wire logic [7:0] src1_in,
   input  wire logic [7:0] src2_in,
   input  wire logic [7:0] src3_in,
   input  wire logic [7:0] src4_in,
   cgis_cfg_if.gates       cfg
);
   logic [3:0] data_r;
   logic [3:0] gate_nxt;
   logic [7:0] sig;
   logic [3:0] gate_r;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_r <= 4'h0;
      end else if (clk_en) begin
         data_r[0] <= src1_in[cfg.sel[2:0]];
         data_r[1] <= src2_in[cfg.sel[6:4]];
         data_r[2] <= src3_in[cfg.sel[10:8]];
         data_r[3] <= src4_in[cfg.sel[14:12]];
      end
   end

   // bit order per gate byte: s4t s4n s3t s3n s2t s2n s1t s1n
   function automatic logic gate_or(input logic [7:0] en,
                                    input logic [7:0] s);
      gate_or = |(en & s);
   endfunction

   always_comb begin
      sig = {data_r[3], ~data_r[3], data_r[2], ~data_r[2],
             data_r[1], ~data_r[1], data_r[0], ~data_r[0]};
      gate_nxt[0] = gate_or(cfg.gate_low[7:0], sig) ^ cfg.pol[0];
      gate_nxt[1] = gate_or(cfg.gate_low[15:8], sig) ^ cfg.pol[1];
      gate_nxt[2] = gate_or(cfg.gate_high[7:0], sig) ^ cfg.pol[2];
      gate_nxt[3] = gate_or(cfg.gate_high[15:8], sig) ^ cfg.pol[3];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_r <= 4'h0;
      end else if (clk_en) begin
         gate_r <= gate_nxt;
      end
   end
   assign cfg.gate_out = gate_r;

   property p_gate1_zero;
      @(posedge mclk) disable iff (rst)
      (clk_en && cfg.gate_low[7:0] == 8'h00 && !cfg.pol[0])
         |=> (gate_r[0] == 1'b0);
   endproperty
   a_gate1_zero: assert property (p_gate1_zero)
      else $error("gate one not zero with no enables");

   property p_gate2_neg;
      @(posedge mclk) disable iff (rst)
      (clk_en && cfg.gate_low[15:8] == 8'h01 && !cfg.pol[1])
         |=> (gate_r[1] == ~data_r[0]);
   endproperty
   a_gate2_neg: assert property (p_gate2_neg)
      else $error("gate two negated source one wrong");

   property p_gate4_true;
      @(posedge mclk) disable iff (rst)
      (clk_en && cfg.gate_high[15:8] == 8'h80 && !cfg.pol[3])
         |=> (gate_r[3] == data_r[3]);
   endproperty
   a_gate4_true: assert property (p_gate4_true)
      else $error("gate four true source four wrong");

   property p_gate3_pol;
      @(posedge mclk) disable iff (rst)
      (clk_en && cfg.gate_high[7:0] == 8'h00 && cfg.pol[2])
         |=> (gate_r[2] == 1'b1);
   endproperty
   a_gate3_pol: assert property (p_gate3_pol)
      else $error("gate three polarity not applied");

   property p_both_pol;
      @(posedge mclk) disable iff (rst)
      (clk_en && cfg.gate_low[7:0] == 8'h03 && !cfg.pol[0])
         |=> (gate_r[0] == 1'b1);
   endproperty
   a_both_pol: assert property (p_both_pol)
      else $error("true or negated not one");

   property p_mux4;
      @(posedge mclk) disable iff (rst)
      clk_en |=> (data_r[3] == $past(src4_in[cfg.sel[14:12]]));
   endproperty
   a_mux4: assert property (p_mux4)
      else $error("source four mux wrong");

   c_gate_hi: cover property (@(posedge mclk) disable iff (rst)
      gate_r[0] && !cfg.pol[0]);
   c_gate_pol: cover property (@(posedge mclk) disable iff (rst)
      gate_r[3] && cfg.pol[3]);
   c_sel4: cover property (@(posedge mclk) disable iff (rst)
      cfg.sel[14:12] == CGIS_S4_OC_THREE);
endmodule
`default_nettype wire

/* rtl/cgis_top.sv */
// apb register file and gate stage of the logic cell input selection.
// assumes apb master on mclk, sources synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module cgis_top
   import cgis_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  src1_in,
   input  wire logic [7:0]  src2_in,
   input  wire logic [7:0]  src3_in,
   input  wire logic [7:0]  src4_in,
   output logic      [3:0]  gate_out
);
   cgis_cfg_if cfg ();

   logic [15:0] gate_low_r;
   logic [15:0] gate_high_r;
   logic [15:0] sel_r;
   logic [3:0]  pol_r;
   logic        acc;
   logic        hit;
   logic [31:0] rd_nxt;

   // one wait state: pready rises in the second cycle of the access phase
   assign acc = psel && penable && !pready && clk_en;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   always_comb begin
      hit = 1'b1;
      rd_nxt = 32'h0000_0000;
      unique case (paddr)
         CGIS_OFF_GATE_LOW:  rd_nxt = {16'h0000, gate_low_r};
         CGIS_OFF_GATE_HIGH: rd_nxt = {16'h0000, gate_high_r};
         CGIS_OFF_SELECT:    rd_nxt = {16'h0000, sel_r};
         CGIS_OFF_POLARITY:  rd_nxt = {28'h0000000, pol_r};
         CGIS_OFF_STATUS:    rd_nxt = {28'h0000000, cfg.gate_out};
         default:            hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_low_r  <= CGIS_GATE_RST;
         gate_high_r <= CGIS_GATE_RST;
         sel_r       <= CGIS_SEL_RST;
         pol_r       <= CGIS_POL_RST;
      end else if (acc && pwrite) begin
         if (paddr == CGIS_OFF_GATE_LOW) begin
            gate_low_r <= merge(gate_low_r, pwdata, pstrb);
         end
         if (paddr == CGIS_OFF_GATE_HIGH) begin
            gate_high_r <= merge(gate_high_r, pwdata, pstrb);
         end
         if (paddr == CGIS_OFF_SELECT) begin
            sel_r <= merge(sel_r, pwdata, pstrb) & CGIS_SEL_MASK;
         end
         if (paddr == CGIS_OFF_POLARITY && pstrb[0]) begin
            pol_r <= pwdata[3:0];
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready  <= acc;
         pslverr <= acc && !hit;
         prdata  <= (acc && !pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end

   assign cfg.gate_low  = gate_low_r;
   assign cfg.gate_high = gate_high_r;
   assign cfg.sel       = sel_r;
   assign cfg.pol       = pol_r;
   assign gate_out      = cfg.gate_out;

   cgis_gate_stage u_stage (
      .mclk    (mclk),
      .rst     (rst),
      .clk_en  (clk_en),
      .src1_in (src1_in),
      .src2_in (src2_in),
      .src3_in (src3_in),
      .src4_in (src4_in),
      .cfg     (cfg.gates)
   );

   property p_write_low;
      @(posedge mclk) disable iff (rst)
      (acc && pwrite && paddr == CGIS_OFF_GATE_LOW && pstrb == 4'hf)
         |=> (gate_low_r == $past(pwdata[15:0]));
   endproperty
   a_write_low: assert property (p_write_low)
      else $error("gate low write lost");

   property p_ready;
      @(posedge mclk) disable iff (rst)
      acc |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready timing wrong");

   c_wr: cover property (@(posedge mclk) disable iff (rst)
      acc && pwrite && paddr == CGIS_OFF_GATE_HIGH);
   c_err: cover property (@(posedge mclk) disable iff (rst) pslverr);
endmodule
`default_nettype wire

/* dv/cgis_src_model.sv */
// peripheral sources feeding the four data-source muxes.
// assumes the bench packs all four source buses into one pattern word.
`timescale 1ns/1ps
`default_nettype none
module cgis_src_model (
   input  wire logic [31:0] pattern,
   output logic      [7:0]  src1,
   output logic      [7:0]  src2,
   output logic      [7:0]  src3,
   output logic      [7:0]  src4
);
   // sources stay driven: on-chip signals never float
   assign src1 = pattern[7:0];
   assign src2 = pattern[15:8];
   assign src3 = pattern[23:16];
   assign src4 = pattern[31:24];
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the gate input selection stage.
// assumes the source model and the design share one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cgis_pkg::*;
   typedef struct {logic [15:0] lo, hi, sel; logic [3:0] pol;
                   logic [31:0] pat; logic [3:0] exp;} cgis_row_type;
   logic         mclk, rst, psel, penable, pwrite, pslverr, pready, slv;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, pattern, rd;
   logic [7:0]   s1, s2, s3, s4;
   logic [3:0]   gate_out;
   int           err_count, samples_checked, k;
   cgis_row_type rows [5] = '{
      '{16'h0201, 16'h0408, 16'h0000, 4'h0, 32'h00010001, 4'ha},
      '{16'h8020, 16'h1040, 16'h0000, 4'h3, 32'h00010001, 4'h6},
      '{16'h0000, 16'h0000, 16'h0000, 4'hf, 32'h00010001, 4'hf},
      '{16'h0002, 16'h0000, 16'h0005, 4'h0, 32'h00000020, 4'h1},
      '{16'h2008, 16'h0000, 16'h0650, 4'h0, 32'h00402000, 4'h3}};

   cgis_src_model i_cgis_src_model (.pattern(pattern), .src1(s1),
      .src2(s2), .src3(s3), .src4(s4));
   cgis_top i_cgis_top (.mclk(mclk), .rst(rst), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src1_in(s1), .src2_in(s2), .src3_in(s3),
      .src4_in(s4), .gate_out(gate_out));

   task automatic chk(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // entered just after an edge; holds the request until pready
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd      = prdata;
      slv     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pready", {31'h0, pready}, 32'h1);
   endtask

   // source to gate_out takes two edges; three leaves margin
   task automatic settle(input logic [31:0] p);
      pattern <= p;
      repeat (3) @(posedge mclk);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      repeat (3000) @(posedge mclk);
      err_count++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pattern = 32'h0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, CGIS_OFF_GATE_LOW, 32'h0);
      chk("low reset", rd, 32'h0);
      apb(1'b0, CGIS_OFF_GATE_HIGH, 32'h0);
      chk("high reset", rd, 32'h0);
      chk("gate reset", {28'h0, gate_out}, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         apb(1'b1, CGIS_OFF_GATE_LOW, {16'h0, rows[i].lo});
         apb(1'b1, CGIS_OFF_GATE_HIGH, {16'h0, rows[i].hi});
         apb(1'b1, CGIS_OFF_SELECT, {16'h0, rows[i].sel});
         apb(1'b1, CGIS_OFF_POLARITY, {28'h0, rows[i].pol});
         settle(rows[i].pat);
         chk("gate_out", {28'h0, gate_out}, {28'h0, rows[i].exp});
      end
      $display("row test done");
      apb(1'b1, CGIS_OFF_POLARITY, 32'h0);
      apb(1'b1, CGIS_OFF_GATE_LOW, 32'h0000_0080);
      for (k = 0; k < 8; k++) begin
         apb(1'b1, CGIS_OFF_SELECT, 32'(k) << 12);
         settle({8'(1 << k), 24'h0});
         chk("src4 code one", {28'h0, gate_out}, 32'h1);
         settle({~8'(1 << k), 24'h0});
         chk("src4 code zero", {28'h0, gate_out}, 32'h0);
      end
      $display("source code test done");
      apb(1'b1, CGIS_OFF_GATE_LOW, 32'hffff_a5c3);
      apb(1'b1, CGIS_OFF_GATE_HIGH, 32'h0000_3c5a);
      apb(1'b1, 12'h020, 32'hffff_ffff);
      chk("unmapped err", {31'h0, slv}, 32'h1);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", {31'h0, slv}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b0, CGIS_OFF_GATE_LOW, 32'h0);
      chk("low readback", rd, 32'h0000_a5c3);
      apb(1'b0, CGIS_OFF_GATE_HIGH, 32'h0);
      chk("high readback", rd, 32'h0000_3c5a);
      $display("register test done");
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, CGIS_OFF_GATE_LOW, 32'h0);
      chk("low rereset", rd, 32'h0);
      chk("gate rereset", {28'h0, gate_out}, 32'h0);
      $display("second reset test done");
      finish_test();
   end
endmodule
`default_nettype wire
